// >>> bench/link_partner.sv
/*
 * link logic model: maps status words and event bits onto the bank's
 * hardware-side inputs. assumes the bench changes its inputs off the edge.
 */
`timescale 1ns/1ps
module link_partner (
	input  wire [63:0] sg_i,                  // general status word
	input  wire [63:0] si_i,                  // init status word
	input  wire [8:0]  ev_i,                  // event pulses
	output wire        link_ready_i,          // link up
	output wire        training_active_i,     // training running
	output wire        device_asleep_i,       // device sleeping
	output wire        lane_order_flipped_i,  // lanes reversed
	output wire        serdes_reset_done_i,   // serdes ready
	output wire [9:0]  far_buffer_credit_i,   // far credits
	output wire [9:0]  local_buffer_credit_i, // local credits
	output wire [15:0] per_lane_inversion_i,  // lane inverted
	output wire [15:0] per_lane_lock_i,       // lane locked
	output wire [15:0] per_lane_partial_i,    // partly aligned
	output wire [15:0] per_lane_full_i,       // fully aligned
	output wire        every_lane_aligned_i,  // all aligned
	output wire [1:0]  transmit_init_phase_i, // tx init phase
	output wire        far_training_seen_i,   // far training
	output wire        nonposted_sent_i,      // np issued
	output wire        posted_write_sent_i,   // posted issued
	output wire        read_req_sent_i,       // read issued
	output wire        bad_packet_rcvd_i,     // poisoned in
	output wire        response_rcvd_i,       // response in
	output wire        response_is_error_i,   // error response
	output wire        tx_retry_i,            // tx retry
	output wire        rx_retry_i,            // rx retry
	output wire        limiter_flip_i         // limiter flip
);
	// ****************************************************************
	// field mapping
	// ****************************************************************
	assign {per_lane_inversion_i, local_buffer_credit_i,
		far_buffer_credit_i, serdes_reset_done_i, lane_order_flipped_i,
		device_asleep_i, training_active_i, link_ready_i} =
		{sg_i[63:48], sg_i[41:32], sg_i[25:16], sg_i[8], sg_i[3:0]};
	assign {far_training_seen_i, transmit_init_phase_i,
		every_lane_aligned_i, per_lane_full_i, per_lane_partial_i,
		per_lane_lock_i} = si_i[51:0];
	assign {limiter_flip_i, rx_retry_i, tx_retry_i, response_is_error_i,
		response_rcvd_i, bad_packet_rcvd_i, read_req_sent_i,
		posted_write_sent_i, nonposted_sent_i} = ev_i;
endmodule

// >>> bench/reg_bank_checker.sv
/*
 * concurrent checks on the register bank ports.
 * assumes one clock and the synchronous high reset of the bank.
 */
`timescale 1ns/1ps
module reg_bank_checker (
	input wire        ref_clk_i,          // clock
	input wire        rst_i,              // reset
	input wire [3:0]  rf_address_i,       // address
	input wire        rf_read_en_i,       // read strobe
	input wire        rf_write_en_i,      // write strobe
	input wire [63:0] rf_write_data_i,    // write data
	input wire [63:0] rf_read_data_o,     // read data
	input wire        rf_access_complete_o, // done
	input wire        rf_invalid_address_o, // unmapped
	input wire        link_ready_i,       // link up
	input wire [9:0]  far_buffer_credit_i, // far credits
	input wire        device_reset_low_o, // device reset
	input wire        scramble_bypass_o,  // bypass
	input wire [4:0]  retry_pkt_trigger_o, // trigger
	input wire [7:0]  slip_pulse_interval_o // slip spacing
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// ****************************************************************
	// sequences
	// ****************************************************************
	sequence s_strobe;
		rf_read_en_i || rf_write_en_i;
	endsequence
	sequence s_ctl_write;
		rf_write_en_i && rf_address_i == 4'h2;
	endsequence
	sequence s_clear_then_read;
		rf_write_en_i && rf_address_i == 4'hb && rf_write_data_i[0]
		##2 rf_read_en_i && rf_address_i == 4'h8;
	endsequence
	// ****************************************************************
	// properties
	// ****************************************************************
	a_done_after_strobe: assert property (s_strobe |=> rf_access_complete_o)
		else $error("no completion after strobe");
	a_no_stray_done: assert property (!(rf_read_en_i || rf_write_en_i)
		|=> !rf_access_complete_o) else $error("stray completion");
	a_flag_unmapped: assert property (s_strobe ##0 rf_address_i > 4'hb
		|=> rf_invalid_address_o) else $error("unmapped not flagged");
	a_flag_mapped: assert property (s_strobe ##0 rf_address_i < 4'hc
		|=> !rf_invalid_address_o) else $error("mapped flagged");
	a_unmapped_zero: assert property (rf_read_en_i && rf_address_i > 4'hb
		|=> rf_read_data_o == 64'h0) else $error("unmapped data");
	a_ctrl_write: assert property (s_ctl_write |=>
		device_reset_low_o == $past(rf_write_data_i[0]) &&
		scramble_bypass_o == $past(rf_write_data_i[3]) &&
		retry_pkt_trigger_o == $past(rf_write_data_i[36:32]) &&
		slip_pulse_interval_o == $past(rf_write_data_i[55:48]))
		else $error("control write lost");
	a_ctrl_hold: assert property (!(rf_write_en_i && rf_address_i == 4'h2)
		|=> $stable(slip_pulse_interval_o) && $stable(device_reset_low_o))
		else $error("control moved");
	a_read_hold: assert property (!rf_read_en_i
		|=> $stable(rf_read_data_o)) else $error("read data moved");
	a_status_copy: assert property (
		rf_read_en_i && rf_address_i == 4'h0 && !$past(rst_i) |=>
		rf_read_data_o[0] == $past(link_ready_i, 2) &&
		rf_read_data_o[25:16] == $past(far_buffer_credit_i, 2))
		else $error("status copy wrong");
	a_clear_wipes: assert property (s_clear_then_read
		|=> rf_read_data_o == 64'h0) else $error("tally not cleared");
endmodule
bind link_reg_bank reg_bank_checker chk_u (.*);

// >>> bench/tb.sv
/*
 * self-checking bench of the register bank with a reference model.
 * assumes the partner model drives the hardware side from random words.
 */
`timescale 1ns/1ps
`include "link_regs_consts.vh"
module tb;
	localparam [63:0] CTL_RST = 64'h0024141000ff001f;
	localparam [63:0] CTL_MSK = 64'h00ff1f1f00ff007f;
	localparam [63:0] SG_MSK  = 64'hffff03ff03ff010f;
	localparam [63:0] SI_MSK  = 64'h000fffffffffffff;
	logic        ref_clk_i = 1'h0, rst_i = 1'h1, run_en = 1'h0;
	logic        rf_read_en_i = 1'h0, rf_write_en_i = 1'h0, clr_m;
	logic [3:0]  rf_address_i = 4'h0;
	logic [63:0] rf_write_data_i = 64'h0, sg_i = 64'h0, si_i = 64'h0;
	logic [63:0] t_m [3:10];
	logic [63:0] ctl_m, sg_m, si_m, exp_q;
	logic [8:0]  ev_i = 9'h0;
	logic [31:0] seed = 32'h1e, r;
	logic [1:0]  ph [0:2] = '{`TX_PHASE_FIRST_NULL, `TX_PHASE_TRAINING,
		`TX_PHASE_SECOND_NULL};
	integer      num_errors = 0, cmp_count = 0, pi = 0, i, p, n;
	wire [63:0] rf_read_data_o;
	wire rf_access_complete_o, rf_invalid_address_o, link_ready_i;
	wire training_active_i, device_asleep_i, lane_order_flipped_i;
	wire serdes_reset_done_i, every_lane_aligned_i, far_training_seen_i;
	wire [9:0] far_buffer_credit_i, local_buffer_credit_i;
	wire [15:0] per_lane_inversion_i, per_lane_lock_i;
	wire [15:0] per_lane_partial_i, per_lane_full_i;
	wire [1:0] transmit_init_phase_i;
	wire nonposted_sent_i, posted_write_sent_i, read_req_sent_i;
	wire bad_packet_rcvd_i, response_rcvd_i, response_is_error_i;
	wire tx_retry_i, rx_retry_i, limiter_flip_i, device_reset_low_o;
	wire lock_permit_o, sleep_request_o, scramble_bypass_o;
	wire bit_run_limiter_ctl_o, first_stack_id_o, suppress_credit_return_o;
	wire [7:0] local_buffer_size_o, slip_pulse_interval_o;
	wire [4:0] retry_pkt_trigger_o, retry_pkt_send_count_o;
	wire [63:0] ctl_out = {8'h0, slip_pulse_interval_o, 3'h0,
		retry_pkt_send_count_o, 3'h0, retry_pkt_trigger_o, 8'h0,
		local_buffer_size_o, 9'h0, suppress_credit_return_o,
		first_stack_id_o, bit_run_limiter_ctl_o, scramble_bypass_o,
		sleep_request_o, lock_permit_o, device_reset_low_o};

	link_reg_bank #(.LOCAL_BUFFER_RESET(8'hff)) dut_u (.*);
	link_partner partner_u (.*);

	// ****************************************************************
	// stimulus helpers
	// ****************************************************************
	initial forever #10 ref_clk_i = ~ref_clk_i;
	function [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		rnd = seed;
	endfunction
	always @(negedge ref_clk_i) begin
		ev_i <= run_en ? 9'(rnd()) : 9'h0;
		if (run_en) begin
			sg_i <= {rnd(), rnd()};
			si_i <= ({rnd(), rnd()} & ~(64'h3 << 49)) |
				({62'h0, ph[pi]} << 49);
			pi <= (pi + 1) % 3;
		end
	end
	// ****************************************************************
	// reference model
	// ****************************************************************
	function [63:0] exp_rd(input [3:0] a);
		case (a)
			4'h0: exp_rd = sg_m & SG_MSK;
			4'h1: exp_rd = si_m & SI_MSK;
			4'h2: exp_rd = ctl_m;
			4'h3, 4'h4, 4'h5, 4'h6, 4'h7: exp_rd = t_m[a];
			4'h8, 4'h9, 4'ha: exp_rd = {32'h0, t_m[a][31:0]};
			4'hb: exp_rd = {63'h0, clr_m};
			default: exp_rd = 64'h0;
		endcase
	endfunction
	always @(posedge ref_clk_i) begin : model
		integer k;
		if (rst_i) begin
			for (k = 3; k < 11; k++) t_m[k] = 64'h0;
			ctl_m = CTL_RST;
			clr_m = 1'h0;
			sg_m = 64'h0;
			si_m = 64'h0;
		end else begin
			if (rf_read_en_i) exp_q = exp_rd(rf_address_i);
			for (k = 0; k < 5; k++)
				if (ev_i[k] && !(k == 4 && ev_i[5])) t_m[k + 3]++;
			for (k = 6; k < 9; k++)
				if (ev_i[k] && !clr_m) t_m[k + 2]++;
			if (clr_m) begin
				for (k = 8; k < 11; k++) t_m[k] = 64'h0;
				clr_m = 1'h0;
			end
			if (rf_write_en_i && rf_address_i == `REG_CONTROL)
				ctl_m = rf_write_data_i & CTL_MSK;
			if (rf_write_en_i && rf_address_i == `REG_TALLY_CLEAR &&
				rf_write_data_i[0]) clr_m = 1'h1;
			sg_m = sg_i;
			si_m = si_i;
		end
	end
	// ****************************************************************
	// checks and accesses
	// ****************************************************************
	task chk(input [63:0] got, input [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task acc(input bit w, input [3:0] a, input [63:0] d);
		rf_read_en_i = !w;
		rf_write_en_i = w;
		rf_address_i = a;
		rf_write_data_i = d;
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk(rf_access_complete_o, 64'h1);
		chk(rf_invalid_address_o, a > 4'hb);
		if (!w) chk(rf_read_data_o, exp_q);
		chk(ctl_out, ctl_m);
	endtask
	task idle;
		rf_read_en_i = 1'h0;
		rf_write_en_i = 1'h0;
		@(negedge ref_clk_i);
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		stop_test;
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (12) @(negedge ref_clk_i);
		rst_i = 1'h0;
		chk(ctl_out, CTL_RST);
		for (i = 0; i < 16; i++) acc(1'b0, 4'(i), 64'h0);
		run_en = 1'h1;
		for (p = 0; p < 2; p++) begin
			for (i = 0; i < 300; i++) begin
				r = rnd();
				acc(r[0], r[7:4], {rnd(), rnd()});
			end
			for (n = 0; n < 8; n++) begin
				acc(1'b1, `REG_TALLY_CLEAR, 64'h1);
				for (i = 11; i > 7; i--) acc(1'b0, 4'(i), 64'h0);
			end
			idle;
			rst_i = 1'h1;
			idle;
			idle;
			rst_i = 1'h0;
			acc(1'b0, `REG_CONTROL, 64'h0);
		end
		idle;
		stop_test;
	end
endmodule

// >>> common/link_regs_consts.vh
/*
 * Register map, field layout and reset values of the link register bank.
 * Assumes a 64-bit register port with word addresses; included by name.
 */
`ifndef LINK_REGS_CONSTS_VH
`define LINK_REGS_CONSTS_VH

// ****************************************************************
// register indices (word address on the register port)
// ****************************************************************
`define REG_STATUS_GENERAL   4'h0
`define REG_STATUS_INIT      4'h1
`define REG_CONTROL          4'h2
`define REG_NONPOSTED_TALLY  4'h3
`define REG_POSTED_TALLY     4'h4
`define REG_READ_TALLY       4'h5
`define REG_BAD_PKT_TALLY    4'h6
`define REG_RESPONSE_TALLY   4'h7
`define REG_TX_RETRY_TALLY   4'h8
`define REG_RX_RETRY_TALLY   4'h9
`define REG_FLIP_TALLY       4'ha
`define REG_TALLY_CLEAR      4'hb

// ****************************************************************
// field widths
// ****************************************************************
`define LANE_W               16
`define CREDIT_W             10
`define RETRY_W              5
`define SLIP_W               8
`define BUFSZ_W              8

// ****************************************************************
// status general field positions
// ****************************************************************
`define SG_LINK_READY        0
`define SG_TRAINING          1
`define SG_ASLEEP            2
`define SG_LANE_FLIP         3
`define SG_SERDES_DONE       8
`define SG_FAR_CREDIT_LSB    16
`define SG_LOCAL_CREDIT_LSB  32
`define SG_INVERSION_LSB     48

// ****************************************************************
// status init field positions
// ****************************************************************
`define SI_LOCK_LSB          0
`define SI_PARTIAL_LSB       16
`define SI_FULL_LSB          32
`define SI_EVERY_ALIGNED     48
`define SI_TX_PHASE_LSB      49
`define SI_FAR_TRAINING      51

// ****************************************************************
// control field positions
// ****************************************************************
`define CT_DEVICE_RESET_LOW  0
`define CT_LOCK_PERMIT       1
`define CT_SLEEP_REQUEST     2
`define CT_SCRAMBLE_BYPASS   3
`define CT_LIMITER_CTL       4
`define CT_FIRST_STACK_ID    5
`define CT_SUPPRESS_CREDIT   6
`define CT_BUFSZ_LSB         16
`define CT_TRIGGER_LSB       32
`define CT_SEND_COUNT_LSB    40
`define CT_SLIP_LSB          48

// ****************************************************************
// reset values of the control fields
// ****************************************************************
`define RST_DEVICE_RESET_LOW 1'h1
`define RST_LOCK_PERMIT      1'h1
`define RST_SLEEP_REQUEST    1'h1
`define RST_SCRAMBLE_BYPASS  1'h1
`define RST_LIMITER_CTL      1'h1
`define RST_FIRST_STACK_ID   1'h0
`define RST_SUPPRESS_CREDIT  1'h0
`define RST_RETRY_TRIGGER    5'h10
`define RST_RETRY_SEND       5'h14
`define RST_SLIP_INTERVAL    8'h24

// ****************************************************************
// transmit init phase codes
// ****************************************************************
`define TX_PHASE_FIRST_NULL  2'h0
`define TX_PHASE_TRAINING    2'h1
`define TX_PHASE_SECOND_NULL 2'h3

`endif

// >>> logic/link_reg_bank.v
/*
 * Register bank of a serial-link memory controller: status, performance
 * tallies, control settings and error tallies.
 * Assumes the link logic drives status and event pulses on ref_clk_i and
 * the register master issues one-cycle read or write strobes.
 */
`timescale 1ns/1ps
`include "link_regs_consts.vh"

// What this block does
// - read-only link ready flag, reset zero, written by link logic
// - read-only training-in-progress flag, reset zero
// - read-only flag showing memory device asleep, reset zero
// - lane order status bit: one means lanes connected reversed
// - read-only serdes reset done flag, reset zero
// - two 10-bit read-only credit counts, far and local buffer
// - per-lane read-only inversion bits, one means lane data inverted
// - per-lane lock, partial and full align vectors plus all-aligned bit
// - 2-bit transmit init phase: 0 first null, 1 training, 3 second null
// - read-only flag set when far end sends training packets
// - 64-bit tallies of received poisoned packets and responses
// - 64-bit tally of issued non-posted requests of every type
// - 64-bit tallies of issued posted writes and read requests
// - read-write active-low memory device reset, resets to one
// - read-write bit permitting descramblers to lock, resets to one
// - sleep request bit resets to one; asleep flag shows real entry
// - read-write test bit bypassing scrambler and descrambler, resets one
// - read-write run length limiter control bit, resets to one
// - debug bit, reset zero, stops credit return packets when set
// - retry trigger count resets 0x10, retry send count resets 0x14
// - bit-slip pulse interval setting, resets to 0x24
// - 32-bit error tallies: tx retries, rx retries, limiter flips
// - tally clear bit clears error tallies then clears itself
// - error responses are not counted in the response tally
module link_reg_bank #(
	parameter [`BUFSZ_W-1:0] LOCAL_BUFFER_RESET = 8'hff // local buffer size
) (
	input  wire                 ref_clk_i,            // clock, 50 MHz
	input  wire                 rst_i,                // sync reset, high
	// register port
	input  wire [3:0]           rf_address_i,         // word address
	input  wire                 rf_read_en_i,         // read strobe
	input  wire                 rf_write_en_i,        // write strobe
	input  wire [63:0]          rf_write_data_i,      // write data
	output reg  [63:0]          rf_read_data_o,       // read data
	output reg                  rf_access_complete_o, // access done pulse
	output reg                  rf_invalid_address_o, // unmapped access
	// status from link logic
	input  wire                 link_ready_i,         // link up
	input  wire                 training_active_i,    // training running
	input  wire                 device_asleep_i,      // device sleeping
	input  wire                 lane_order_flipped_i, // lanes reversed
	input  wire                 serdes_reset_done_i,  // serdes ready
	input  wire [`CREDIT_W-1:0] far_buffer_credit_i,  // far credits left
	input  wire [`CREDIT_W-1:0] local_buffer_credit_i, // local credits
	input  wire [`LANE_W-1:0]   per_lane_inversion_i, // lane inverted
	input  wire [`LANE_W-1:0]   per_lane_lock_i,      // lane locked
	input  wire [`LANE_W-1:0]   per_lane_partial_i,   // partially aligned
	input  wire [`LANE_W-1:0]   per_lane_full_i,      // fully aligned
	input  wire                 every_lane_aligned_i, // all aligned
	input  wire [1:0]           transmit_init_phase_i, // tx init phase
	input  wire                 far_training_seen_i,  // far sends training
	// event pulses from link logic
	input  wire                 nonposted_sent_i,     // np request issued
	input  wire                 posted_write_sent_i,  // posted write issued
	input  wire                 read_req_sent_i,      // read issued
	input  wire                 bad_packet_rcvd_i,    // poisoned received
	input  wire                 response_rcvd_i,      // response received
	input  wire                 response_is_error_i,  // with response: error
	input  wire                 tx_retry_i,           // tx link retry
	input  wire                 rx_retry_i,           // rx retry succeeded
	input  wire                 limiter_flip_i,       // limiter bit flip
	// control to link logic
	output reg                  device_reset_low_o,   // device reset, low
	output reg                  lock_permit_o,        // allow lock
	output reg                  sleep_request_o,      // request sleep
	output reg                  scramble_bypass_o,    // scrambler off
	output reg                  bit_run_limiter_ctl_o, // limiter control
	output reg                  first_stack_id_o,     // first stack id
	output reg                  suppress_credit_return_o, // no tret
	output reg  [`BUFSZ_W-1:0]  local_buffer_size_o,  // rx buffer size
	output reg  [`RETRY_W-1:0]  retry_pkt_trigger_o,  // rx retry threshold
	output reg  [`RETRY_W-1:0]  retry_pkt_send_count_o, // retries to send
	output reg  [`SLIP_W-1:0]   slip_pulse_interval_o // slip spacing
);

	// ****************************************************************
	// status capture
	// ****************************************************************
	reg                 link_ready_q;
	reg                 training_active_q;
	reg                 device_asleep_q;
	reg                 lane_order_flipped_q;
	reg                 serdes_reset_done_q;
	reg [`CREDIT_W-1:0] far_buffer_credit_q;
	reg [`CREDIT_W-1:0] local_buffer_credit_q;
	reg [`LANE_W-1:0]   per_lane_inversion_q;
	reg [`LANE_W-1:0]   per_lane_lock_q;
	reg [`LANE_W-1:0]   per_lane_partial_q;
	reg [`LANE_W-1:0]   per_lane_full_q;
	reg                 every_lane_aligned_q;
	reg [1:0]           transmit_init_phase_q;
	reg                 far_training_seen_q;

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			link_ready_q          <= 1'b0;
			training_active_q     <= 1'b0;
			device_asleep_q       <= 1'b0;
			lane_order_flipped_q  <= 1'b0;
			serdes_reset_done_q   <= 1'b0;
			far_buffer_credit_q   <= {`CREDIT_W{1'b0}};
			local_buffer_credit_q <= {`CREDIT_W{1'b0}};
			per_lane_inversion_q  <= {`LANE_W{1'b0}};
			per_lane_lock_q       <= {`LANE_W{1'b0}};
			per_lane_partial_q    <= {`LANE_W{1'b0}};
			per_lane_full_q       <= {`LANE_W{1'b0}};
			every_lane_aligned_q  <= 1'b0;
			transmit_init_phase_q <= `TX_PHASE_FIRST_NULL;
			far_training_seen_q   <= 1'b0;
		end else begin
			link_ready_q          <= link_ready_i;
			training_active_q     <= training_active_i;
			device_asleep_q       <= device_asleep_i;
			lane_order_flipped_q  <= lane_order_flipped_i;
			serdes_reset_done_q   <= serdes_reset_done_i;
			far_buffer_credit_q   <= far_buffer_credit_i;
			local_buffer_credit_q <= local_buffer_credit_i;
			per_lane_inversion_q  <= per_lane_inversion_i;
			per_lane_lock_q       <= per_lane_lock_i;
			per_lane_partial_q    <= per_lane_partial_i;
			per_lane_full_q       <= per_lane_full_i;
			every_lane_aligned_q  <= every_lane_aligned_i;
			transmit_init_phase_q <= transmit_init_phase_i;
			far_training_seen_q   <= far_training_seen_i;
		end
	end

	// ****************************************************************
	// performance tallies
	// ****************************************************************
	// order: nonposted, posted, read, poisoned, response
	reg  [63:0] perf_q [0:4];
	wire [4:0]  perf_inc;

	assign perf_inc[0] = nonposted_sent_i;
	assign perf_inc[1] = posted_write_sent_i;
	assign perf_inc[2] = read_req_sent_i;
	assign perf_inc[3] = bad_packet_rcvd_i;
	// error responses stay out of the response tally
	assign perf_inc[4] = response_rcvd_i & ~response_is_error_i;

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_perf
			always @(posedge ref_clk_i) begin
				if (rst_i) begin
					perf_q[gi] <= 64'h0;
				end else if (perf_inc[gi]) begin
					perf_q[gi] <= perf_q[gi] + 64'h1;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// error tallies and their clear
	// ****************************************************************
	// order: tx retry, rx retry, limiter flip
	reg  [31:0] err_q [0:2];
	wire [2:0]  err_inc;
	reg         tally_clear_q;
	wire        clear_wr;

	assign err_inc  = {limiter_flip_i, rx_retry_i, tx_retry_i};
	assign clear_wr = rf_write_en_i
		&& (rf_address_i == `REG_TALLY_CLEAR)
		&& rf_write_data_i[0];

	// set by software, dropped by hardware once the clear is done
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			tally_clear_q <= 1'b0;
		end else if (clear_wr) begin
			tally_clear_q <= 1'b1;
		end else begin
			tally_clear_q <= 1'b0;
		end
	end

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_err
			always @(posedge ref_clk_i) begin
				if (rst_i) begin
					err_q[gi] <= 32'h0;
				end else if (tally_clear_q) begin
					// clear wins over an increment in the same cycle
					err_q[gi] <= 32'h0;
				end else if (err_inc[gi]) begin
					err_q[gi] <= err_q[gi] + 32'h1;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// control settings
	// ****************************************************************
	wire ctl_wr;

	assign ctl_wr = rf_write_en_i && (rf_address_i == `REG_CONTROL);

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			device_reset_low_o       <= `RST_DEVICE_RESET_LOW;
			lock_permit_o            <= `RST_LOCK_PERMIT;
			sleep_request_o          <= `RST_SLEEP_REQUEST;
			scramble_bypass_o        <= `RST_SCRAMBLE_BYPASS;
			bit_run_limiter_ctl_o    <= `RST_LIMITER_CTL;
			first_stack_id_o         <= `RST_FIRST_STACK_ID;
			suppress_credit_return_o <= `RST_SUPPRESS_CREDIT;
			local_buffer_size_o      <= LOCAL_BUFFER_RESET;
			retry_pkt_trigger_o      <= `RST_RETRY_TRIGGER;
			retry_pkt_send_count_o   <= `RST_RETRY_SEND;
			slip_pulse_interval_o    <= `RST_SLIP_INTERVAL;
		end else if (ctl_wr) begin
			device_reset_low_o <=
				rf_write_data_i[`CT_DEVICE_RESET_LOW];
			lock_permit_o <=
				rf_write_data_i[`CT_LOCK_PERMIT];
			sleep_request_o <=
				rf_write_data_i[`CT_SLEEP_REQUEST];
			scramble_bypass_o <=
				rf_write_data_i[`CT_SCRAMBLE_BYPASS];
			bit_run_limiter_ctl_o <=
				rf_write_data_i[`CT_LIMITER_CTL];
			first_stack_id_o <=
				rf_write_data_i[`CT_FIRST_STACK_ID];
			suppress_credit_return_o <=
				rf_write_data_i[`CT_SUPPRESS_CREDIT];
			local_buffer_size_o <= rf_write_data_i[
				`CT_BUFSZ_LSB +: `BUFSZ_W];
			retry_pkt_trigger_o <= rf_write_data_i[
				`CT_TRIGGER_LSB +: `RETRY_W];
			retry_pkt_send_count_o <= rf_write_data_i[
				`CT_SEND_COUNT_LSB +: `RETRY_W];
			slip_pulse_interval_o <= rf_write_data_i[
				`CT_SLIP_LSB +: `SLIP_W];
		end
	end

	// ****************************************************************
	// register read mux
	// ****************************************************************
	reg [63:0] rd_d;
	reg        bad_addr_d;

	always @* begin
		rd_d       = 64'h0;
		bad_addr_d = 1'b0;
		case (rf_address_i)
			`REG_STATUS_GENERAL: begin
				rd_d[`SG_LINK_READY]  = link_ready_q;
				rd_d[`SG_TRAINING]    = training_active_q;
				rd_d[`SG_ASLEEP]      = device_asleep_q;
				rd_d[`SG_LANE_FLIP]   = lane_order_flipped_q;
				rd_d[`SG_SERDES_DONE] = serdes_reset_done_q;
				rd_d[`SG_FAR_CREDIT_LSB +: `CREDIT_W] =
					far_buffer_credit_q;
				rd_d[`SG_LOCAL_CREDIT_LSB +: `CREDIT_W] =
					local_buffer_credit_q;
				rd_d[`SG_INVERSION_LSB +: `LANE_W] =
					per_lane_inversion_q;
			end
			`REG_STATUS_INIT: begin
				rd_d[`SI_LOCK_LSB +: `LANE_W]    = per_lane_lock_q;
				rd_d[`SI_PARTIAL_LSB +: `LANE_W] = per_lane_partial_q;
				rd_d[`SI_FULL_LSB +: `LANE_W]    = per_lane_full_q;
				rd_d[`SI_EVERY_ALIGNED]          = every_lane_aligned_q;
				rd_d[`SI_TX_PHASE_LSB +: 2]      = transmit_init_phase_q;
				rd_d[`SI_FAR_TRAINING]           = far_training_seen_q;
			end
			`REG_CONTROL: begin
				rd_d[`CT_DEVICE_RESET_LOW] = device_reset_low_o;
				rd_d[`CT_LOCK_PERMIT]      = lock_permit_o;
				rd_d[`CT_SLEEP_REQUEST]    = sleep_request_o;
				rd_d[`CT_SCRAMBLE_BYPASS]  = scramble_bypass_o;
				rd_d[`CT_LIMITER_CTL]      = bit_run_limiter_ctl_o;
				rd_d[`CT_FIRST_STACK_ID]   = first_stack_id_o;
				rd_d[`CT_SUPPRESS_CREDIT]  = suppress_credit_return_o;
				rd_d[`CT_BUFSZ_LSB +: `BUFSZ_W] = local_buffer_size_o;
				rd_d[`CT_TRIGGER_LSB +: `RETRY_W] = retry_pkt_trigger_o;
				rd_d[`CT_SEND_COUNT_LSB +: `RETRY_W] =
					retry_pkt_send_count_o;
				rd_d[`CT_SLIP_LSB +: `SLIP_W] = slip_pulse_interval_o;
			end
			`REG_NONPOSTED_TALLY: rd_d = perf_q[0];
			`REG_POSTED_TALLY:    rd_d = perf_q[1];
			`REG_READ_TALLY:      rd_d = perf_q[2];
			`REG_BAD_PKT_TALLY:   rd_d = perf_q[3];
			`REG_RESPONSE_TALLY:  rd_d = perf_q[4];
			`REG_TX_RETRY_TALLY:  rd_d[31:0] = err_q[0];
			`REG_RX_RETRY_TALLY:  rd_d[31:0] = err_q[1];
			`REG_FLIP_TALLY:      rd_d[31:0] = err_q[2];
			`REG_TALLY_CLEAR:     rd_d[0] = tally_clear_q;
			default:              bad_addr_d = 1'b1;
		endcase
	end

	// ****************************************************************
	// register port answer
	// ****************************************************************
	// one access answered per strobe, one cycle later
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			rf_read_data_o       <= 64'h0;
			rf_access_complete_o <= 1'b0;
			rf_invalid_address_o <= 1'b0;
		end else begin
			rf_access_complete_o <= rf_read_en_i | rf_write_en_i;
			rf_invalid_address_o <= (rf_read_en_i | rf_write_en_i)
				& bad_addr_d;
			if (rf_read_en_i) begin
				rf_read_data_o <= rd_d;
			end
		end
	end

endmodule
